// ---- dtfm_defines.vh ----
// Register indices, field positions and constants of the dual four-mode timer
`ifndef DTFM_DEFINES_VH
`define DTFM_DEFINES_VH

// Register indices (word address on the bus; byte address is four times this)
`define DTFM_IDX_CTRL      8'h88
`define DTFM_IDX_MODE      8'h89
`define DTFM_IDX_A_LOW     8'h8a
`define DTFM_IDX_B_LOW     8'h8b
`define DTFM_IDX_A_HIGH    8'h8c
`define DTFM_IDX_B_HIGH    8'h8d
`define DTFM_IDX_IEN       8'ha8
`define DTFM_IDX_PSC       8'he7
`define DTFM_IDX_CTRL_SET  8'hf8
`define DTFM_IDX_CTRL_CLR  8'hf9

// Control register fields
`define DTFM_CTRL_TF_B     7
`define DTFM_CTRL_TR_B     6
`define DTFM_CTRL_TF_A     5
`define DTFM_CTRL_TR_A     4

// Interrupt enable fields
`define DTFM_IEN_GLOBAL    7
`define DTFM_IEN_B         3
`define DTFM_IEN_A         1

// Prescale register fields
`define DTFM_PSC_EXT_SEL   7
`define DTFM_PSC_A_HI      6
`define DTFM_PSC_A_LO      4
`define DTFM_PSC_B_HI      2
`define DTFM_PSC_B_LO      0

// Mode register fields
`define DTFM_MODE_GATE_B   7
`define DTFM_MODE_SRC_B    6
`define DTFM_MODE_B_HI     5
`define DTFM_MODE_B_LO     4
`define DTFM_MODE_GATE_A   3
`define DTFM_MODE_SRC_A    2
`define DTFM_MODE_A_HI     1
`define DTFM_MODE_A_LO     0

// Mode field codes
`define DTFM_M13           2'h0
`define DTFM_M16           2'h1
`define DTFM_M8R           2'h2
`define DTFM_MSPLIT        2'h3

// Reset values and counts
`define DTFM_BYTE_RST      8'h00
`define DTFM_PSC_RST       7'h00
`define DTFM_DIV12_LAST    4'hb
`define DTFM_DIV12_RST     4'h0
`define DTFM_DIV_MAX_LAST  7'h7f
`define DTFM_BYTE_FULL     8'hff
`define DTFM_LOW5_FULL     5'h1f

`endif

// ---- dtfm_timer.v ----
// Dual four-mode timer with Avalon-MM register slave
//
// Function
// - Mode 0: 13-bit count, low byte bits 7:5 idle
// - Mode 0 wrap 0xFF1F to 0 sets flag
// - Flag readable; enabled flag raises interrupt request
// - Mode 1: 16-bit count, flag on wrap
// - Mode 2: low byte counts, flag on wrap
// - Mode 2 wrap reloads low from high byte
// - Mode 3: A high byte counts at cpu/12
// - Mode 3: pin gating only on A low
// - Mode 3: A run enables low, sets A flag
// - Mode 3: B run drives A high, B flag
// - A in mode 3: B counts without flag
// - Flag cleared by service or write zero
// - Flags at control bits 5 and 7
// - Run bits at control bits 4 and 6
// - Prescale bit 7 selects A external source
// - Prescale bits 6:4 set A divider
// - Prescale bits 2:0 set B divider
// - Enable bits 1, 3 gated by bit 7
// - Count bytes read/write, reset to zero
// - Mode codes; B code 11 reserved
// - Source bit: cpu/12 or divided external
// - Gate bit gates count with its pin
//
// The Avalon-MM slave port was decided locally.
`include "dtfm_defines.vh"
`default_nettype none

module dtfm_timer (
  input  wire        clk_sys,
  input  wire        rst_n,
  input  wire [7:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        fosc_in,
  input  wire        flosc_in,
  input  wire        ext_irq_pin_a,
  input  wire        ext_irq_pin_b,
  input  wire        irq_ack_a,
  input  wire        irq_ack_b,
  output wire        irq_req_a,
  output wire        irq_req_b
);

  // Divider terminal count: code 0 gives /128, code 7 gives /1
  function [6:0] dtfm_div_last;
    input [2:0] code;
    begin
      dtfm_div_last = `DTFM_DIV_MAX_LAST >> code;
    end
  endfunction

  // One count step: returns {overflow, high, low}
  function [16:0] dtfm_step;
    input [1:0] m;
    input [7:0] h;
    input [7:0] l;
    reg   [13:0] t13;
    reg   [16:0] t16;
    reg   [8:0]  t8;
    begin
      t13 = {1'b0, h, l[4:0]} + 14'h1;
      t16 = {1'b0, h, l} + 17'h1;
      t8  = {1'b0, l} + 9'h1;
      case (m)
        `DTFM_M13: begin
          // Upper low-byte bits keep their value
          dtfm_step = {t13[13], t13[12:5], l[7:5], t13[4:0]};
        end
        `DTFM_M16: begin
          dtfm_step = t16;
        end
        `DTFM_M8R: begin
          if (l == `DTFM_BYTE_FULL) begin
            dtfm_step = {1'b1, h, h};
          end else begin
            dtfm_step = {1'b0, h, t8[7:0]};
          end
        end
        default: begin
          dtfm_step = {t8[8], h, t8[7:0]};
        end
      endcase
    end
  endfunction

  // Pending request: flag qualified by its own and the global enable
  function dtfm_pend;
    input flag;
    input en;
    input glob;
    begin
      dtfm_pend = flag & en & glob;
    end
  endfunction

  // Register file
  reg  [7:0]  timer_control_flags_r;
  reg  [7:0]  timer_mode_select_r;
  reg  [7:0]  interrupt_enable_main_r;
  reg  [7:0]  timer_prescale_select_r;
  reg  [7:0]  timer_a_low_count_r;
  reg  [7:0]  timer_a_high_count_r;
  reg  [7:0]  timer_b_low_count_r;
  reg  [7:0]  timer_b_high_count_r;
  reg  [31:0] readdata_r;
  reg         waitrequest_r;
  reg         irq_req_a_r;
  reg         irq_req_b_r;

  // Input synchronisers: {flosc, fosc, pin b, pin a}
  reg  [3:0]  sync1_r;
  reg  [3:0]  sync2_r;
  reg  [3:0]  sync3_r;
  reg  [3:0]  stable_r;
  reg  [6:0]  psc_a_r;
  reg  [6:0]  psc_b_r;
  reg  [3:0]  div12_r;

  wire [3:0]  agree      = ~(sync2_r ^ sync3_r);
  wire [3:0]  stable_nxt = (agree & sync2_r) | (~agree & stable_r);
  wire [3:0]  rise       = stable_nxt & ~stable_r;

  wire        run_a   = timer_control_flags_r[`DTFM_CTRL_TR_A];
  wire        run_b   = timer_control_flags_r[`DTFM_CTRL_TR_B];
  wire        flag_a  = timer_control_flags_r[`DTFM_CTRL_TF_A];
  wire        flag_b  = timer_control_flags_r[`DTFM_CTRL_TF_B];
  wire [1:0]  mode_a  = timer_mode_select_r[`DTFM_MODE_A_HI:`DTFM_MODE_A_LO];
  wire [1:0]  mode_b  = timer_mode_select_r[`DTFM_MODE_B_HI:`DTFM_MODE_B_LO];
  wire        split_a = (mode_a == `DTFM_MSPLIT);
  wire [2:0]  code_a  = timer_prescale_select_r[`DTFM_PSC_A_HI:`DTFM_PSC_A_LO];
  wire [2:0]  code_b  = timer_prescale_select_r[`DTFM_PSC_B_HI:`DTFM_PSC_B_LO];

  // Bus handshake: request held one cycle, taken when waitrequest is low
  wire        req_new  = (avs_read | avs_write) & waitrequest_r;
  wire        wr_take  = avs_write & ~waitrequest_r & avs_byteenable[0];
  wire [7:0]  wbyte    = avs_writedata[7:0];

  wire        wr_ctrl  = wr_take & (avs_address == `DTFM_IDX_CTRL);
  wire        wr_set   = wr_take & (avs_address == `DTFM_IDX_CTRL_SET);
  wire        wr_clr   = wr_take & (avs_address == `DTFM_IDX_CTRL_CLR);
  wire        wr_a_lo  = wr_take & (avs_address == `DTFM_IDX_A_LOW);
  wire        wr_a_hi  = wr_take & (avs_address == `DTFM_IDX_A_HIGH);
  wire        wr_b_lo  = wr_take & (avs_address == `DTFM_IDX_B_LOW);
  wire        wr_b_hi  = wr_take & (avs_address == `DTFM_IDX_B_HIGH);
  wire        wr_mode  = wr_take & (avs_address == `DTFM_IDX_MODE);
  wire        wr_ien   = wr_take & (avs_address == `DTFM_IDX_IEN);
  wire        wr_psc   = wr_take & (avs_address == `DTFM_IDX_PSC);

  // Slow source ticks, each exactly one clk_sys cycle
  wire        tick12  = (div12_r == `DTFM_DIV12_LAST);
  wire        edge_a  = timer_prescale_select_r[`DTFM_PSC_EXT_SEL] ?
                        rise[3] : rise[2];
  wire        edge_b  = rise[2];
  wire        ptick_a = edge_a & (psc_a_r == dtfm_div_last(code_a));
  wire        ptick_b = edge_b & (psc_b_r == dtfm_div_last(code_b));
  wire        src_a   = timer_mode_select_r[`DTFM_MODE_SRC_A] ? ptick_a : tick12;
  wire        src_b   = timer_mode_select_r[`DTFM_MODE_SRC_B] ? ptick_b : tick12;
  wire        gate_a  = ~timer_mode_select_r[`DTFM_MODE_GATE_A] | stable_r[0];
  wire        gate_b  = ~timer_mode_select_r[`DTFM_MODE_GATE_B] | stable_r[1];

  // Count enables; a cleared run bit simply freezes the count
  wire        inc_a   = run_a & gate_a & src_a;
  wire        inc_ah  = split_a & run_b & tick12;
  wire        inc_b   = run_b & gate_b & src_b & (mode_b != `DTFM_MSPLIT);

  wire [16:0] step_a  = dtfm_step(mode_a, timer_a_high_count_r, timer_a_low_count_r);
  wire [16:0] step_b  = dtfm_step(mode_b, timer_b_high_count_r, timer_b_low_count_r);

  reg  [7:0]  a_lo_nxt;
  reg  [7:0]  a_hi_nxt;
  reg  [7:0]  b_lo_nxt;
  reg  [7:0]  b_hi_nxt;
  reg         ovf_a;
  reg         ovf_b;
  reg  [7:0]  ctrl_nxt;
  reg  [31:0] rdata_nxt;

  always @* begin
    a_lo_nxt = timer_a_low_count_r;
    a_hi_nxt = timer_a_high_count_r;
    b_lo_nxt = timer_b_low_count_r;
    b_hi_nxt = timer_b_high_count_r;
    ovf_a    = 1'b0;
    ovf_b    = 1'b0;
    if (inc_a) begin
      a_lo_nxt = step_a[7:0];
      if (!split_a) begin
        a_hi_nxt = step_a[15:8];
      end
      ovf_a = step_a[16];
    end
    if (inc_ah) begin
      a_hi_nxt = timer_a_high_count_r + 8'h1;
      ovf_b    = (timer_a_high_count_r == `DTFM_BYTE_FULL);
    end
    if (inc_b) begin
      b_lo_nxt = step_b[7:0];
      b_hi_nxt = step_b[15:8];
      // Timer B keeps counting but its wrap is lost while A is split
      if (!split_a) begin
        ovf_b = step_b[16];
      end
    end
    // Software load wins over a count in the same cycle
    if (wr_a_lo) begin
      a_lo_nxt = wbyte;
    end
    if (wr_a_hi) begin
      a_hi_nxt = wbyte;
    end
    if (wr_b_lo) begin
      b_lo_nxt = wbyte;
    end
    if (wr_b_hi) begin
      b_hi_nxt = wbyte;
    end
  end

  // Control register: writing one to a flag does nothing, hardware set wins
  always @* begin
    ctrl_nxt = timer_control_flags_r;
    if (wr_ctrl) begin
      ctrl_nxt[`DTFM_CTRL_TR_A] = wbyte[`DTFM_CTRL_TR_A];
      ctrl_nxt[`DTFM_CTRL_TR_B] = wbyte[`DTFM_CTRL_TR_B];
      ctrl_nxt[`DTFM_CTRL_TF_A] = flag_a & wbyte[`DTFM_CTRL_TF_A];
      ctrl_nxt[`DTFM_CTRL_TF_B] = flag_b & wbyte[`DTFM_CTRL_TF_B];
    end
    // Single-bit set and clear ports avoid the lost-flag hazard of RMW
    if (wr_set) begin
      ctrl_nxt[`DTFM_CTRL_TR_A] = run_a | wbyte[`DTFM_CTRL_TR_A];
      ctrl_nxt[`DTFM_CTRL_TR_B] = run_b | wbyte[`DTFM_CTRL_TR_B];
    end
    if (wr_clr) begin
      ctrl_nxt[`DTFM_CTRL_TR_A] = run_a & ~wbyte[`DTFM_CTRL_TR_A];
      ctrl_nxt[`DTFM_CTRL_TR_B] = run_b & ~wbyte[`DTFM_CTRL_TR_B];
      ctrl_nxt[`DTFM_CTRL_TF_A] = flag_a & ~wbyte[`DTFM_CTRL_TF_A];
      ctrl_nxt[`DTFM_CTRL_TF_B] = flag_b & ~wbyte[`DTFM_CTRL_TF_B];
    end
    // Service clear first, so a wrap in the same cycle still sets
    if (irq_ack_a) begin
      ctrl_nxt[`DTFM_CTRL_TF_A] = 1'b0;
    end
    if (irq_ack_b) begin
      ctrl_nxt[`DTFM_CTRL_TF_B] = 1'b0;
    end
    if (ovf_a) begin
      ctrl_nxt[`DTFM_CTRL_TF_A] = 1'b1;
    end
    if (ovf_b) begin
      ctrl_nxt[`DTFM_CTRL_TF_B] = 1'b1;
    end
    // Bits of other blocks read as zero here
    ctrl_nxt[3:0] = 4'h0;
  end

  // Read mux, unmapped indices read zero
  always @* begin
    rdata_nxt = 32'h0000_0000;
    if (avs_address == `DTFM_IDX_CTRL) begin
      rdata_nxt[7:0] = timer_control_flags_r;
    end else if (avs_address == `DTFM_IDX_MODE) begin
      rdata_nxt[7:0] = timer_mode_select_r;
    end else if (avs_address == `DTFM_IDX_A_LOW) begin
      rdata_nxt[7:0] = timer_a_low_count_r;
    end else if (avs_address == `DTFM_IDX_B_LOW) begin
      rdata_nxt[7:0] = timer_b_low_count_r;
    end else if (avs_address == `DTFM_IDX_A_HIGH) begin
      rdata_nxt[7:0] = timer_a_high_count_r;
    end else if (avs_address == `DTFM_IDX_B_HIGH) begin
      rdata_nxt[7:0] = timer_b_high_count_r;
    end else if (avs_address == `DTFM_IDX_IEN) begin
      rdata_nxt[7:0] = interrupt_enable_main_r;
    end else if (avs_address == `DTFM_IDX_PSC) begin
      rdata_nxt[7:0] = timer_prescale_select_r;
    end
  end

  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r                 <= 4'h0;
      sync2_r                 <= 4'h0;
      sync3_r                 <= 4'h0;
      stable_r                <= 4'h0;
      psc_a_r                 <= `DTFM_PSC_RST;
      psc_b_r                 <= `DTFM_PSC_RST;
      div12_r                 <= `DTFM_DIV12_RST;
      timer_control_flags_r   <= `DTFM_BYTE_RST;
      timer_mode_select_r     <= `DTFM_BYTE_RST;
      interrupt_enable_main_r <= `DTFM_BYTE_RST;
      timer_prescale_select_r <= `DTFM_BYTE_RST;
      timer_a_low_count_r     <= `DTFM_BYTE_RST;
      timer_a_high_count_r    <= `DTFM_BYTE_RST;
      timer_b_low_count_r     <= `DTFM_BYTE_RST;
      timer_b_high_count_r    <= `DTFM_BYTE_RST;
      readdata_r              <= 32'h0000_0000;
      waitrequest_r           <= 1'b1;
      irq_req_a_r             <= 1'b0;
      irq_req_b_r             <= 1'b0;
    end else begin
      // A level counts once the second and third stages agree
      sync1_r  <= {flosc_in, fosc_in, ext_irq_pin_b, ext_irq_pin_a};
      sync2_r  <= sync1_r;
      sync3_r  <= sync2_r;
      stable_r <= stable_nxt;

      // Free-running, so split and normal users share one phase
      if (tick12) begin
        div12_r <= `DTFM_DIV12_RST;
      end else begin
        div12_r <= div12_r + 4'h1;
      end
      // Prescalers run freely so a code change takes effect within one period
      if (ptick_a) begin
        psc_a_r <= `DTFM_PSC_RST;
      end else if (edge_a) begin
        psc_a_r <= (psc_a_r + 7'h1) & dtfm_div_last(code_a);
      end
      if (ptick_b) begin
        psc_b_r <= `DTFM_PSC_RST;
      end else if (edge_b) begin
        psc_b_r <= (psc_b_r + 7'h1) & dtfm_div_last(code_b);
      end

      timer_control_flags_r <= ctrl_nxt;
      timer_a_low_count_r   <= a_lo_nxt;
      timer_a_high_count_r  <= a_hi_nxt;
      timer_b_low_count_r   <= b_lo_nxt;
      timer_b_high_count_r  <= b_hi_nxt;

      if (wr_mode) begin
        timer_mode_select_r <= wbyte;
      end
      if (wr_ien) begin
        interrupt_enable_main_r <= {wbyte[`DTFM_IEN_GLOBAL], 3'h0,
                                    wbyte[`DTFM_IEN_B], 1'b0,
                                    wbyte[`DTFM_IEN_A], 1'b0};
      end
      if (wr_psc) begin
        timer_prescale_select_r <= {wbyte[7:4], 1'b0, wbyte[2:0]};
      end

      // One wait cycle, then the request is taken
      if (req_new) begin
        waitrequest_r <= 1'b0;
        readdata_r    <= rdata_nxt;
      end else begin
        waitrequest_r <= 1'b1;
      end

      irq_req_a_r <= dtfm_pend(flag_a, interrupt_enable_main_r[`DTFM_IEN_A],
                               interrupt_enable_main_r[`DTFM_IEN_GLOBAL]);
      irq_req_b_r <= dtfm_pend(flag_b, interrupt_enable_main_r[`DTFM_IEN_B],
                               interrupt_enable_main_r[`DTFM_IEN_GLOBAL]);
    end
  end

  assign avs_readdata    = readdata_r;
  assign avs_waitrequest = waitrequest_r;
  assign irq_req_a       = irq_req_a_r;
  assign irq_req_b       = irq_req_b_r;

endmodule // dtfm_timer

`default_nettype wire

// ---- dtfm_timer_chk.sv ----
// Port-level checker for the dual four-mode timer
`include "dtfm_defines.vh"
`default_nettype none
module dtfm_timer_chk (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        fosc_in,
  input wire logic        flosc_in,
  input wire logic        ext_irq_pin_a,
  input wire logic        ext_irq_pin_b,
  input wire logic        irq_ack_a,
  input wire logic        irq_ack_b,
  input wire logic        irq_req_a,
  input wire logic        irq_req_b
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire logic rd_ok;
  wire logic wr_take;
  wire logic mapped;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign wr_take = avs_write && !avs_waitrequest;
  assign mapped = avs_address inside {[8'h88:8'h8d], 8'ha8, 8'he7, 8'hf8, 8'hf9};

  wait_one_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  req_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  rd_upper_a: assert property (avs_readdata[31:8] == 24'h0)
    else $error("read upper bits set");
  rd_hold_a: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved at rest");
  ctrl_low_a: assert property (rd_ok && avs_address == `DTFM_IDX_CTRL |-> avs_readdata[3:0] == 4'h0)
    else $error("control low bits set");
  psc_rsv_a: assert property (rd_ok && avs_address == `DTFM_IDX_PSC |-> !avs_readdata[3])
    else $error("prescale bit 3 set");
  ien_bits_a: assert property (rd_ok && avs_address == `DTFM_IDX_IEN |-> (avs_readdata[7:0] & 8'h75) == 8'h00)
    else $error("enable spare bits set");
  unmap_zero_a: assert property (rd_ok && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  ack_clear_a: assert property (irq_ack_a |-> ##2 !irq_req_a)
    else $error("ack did not clear request");
  fall_cause_a: assert property ($fell(irq_req_a) |-> $past(irq_ack_a, 2) || $past(wr_take, 2))
    else $error("request a dropped alone");
  fall_cause_b_a: assert property ($fell(irq_req_b) |-> $past(irq_ack_b, 2) || $past(wr_take, 2))
    else $error("request b dropped alone");
endmodule // dtfm_timer_chk

bind dtfm_timer dtfm_timer_chk u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fosc_in(fosc_in),
  .flosc_in(flosc_in), .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
  .irq_ack_a(irq_ack_a), .irq_ack_b(irq_ack_b), .irq_req_a(irq_req_a), .irq_req_b(irq_req_b)
);
`default_nettype wire

// ---- dtfm_timer_tb_top.sv ----
// Self-checking bench for the dual four-mode timer
`include "dtfm_defines.vh"
`default_nettype none
module dtfm_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic        rd_r = 1'b0;
  logic        wr_r = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0]  be = 4'h1;
  wire  [31:0] rdat;
  wire         wait_r;
  logic        fosc_in = 1'b0;
  logic        pin_a = 1'b1;
  logic        ack_a = 1'b0;
  logic        ack_b = 1'b0;
  logic        pin_b = 1'b1;
  logic        flosc_in = 1'b0;
  logic [3:0]  sdiv_r = 4'h0;
  wire         req_a;
  wire         req_b;
  logic [1:0]  div_r = 2'h0;
  int          num_errors = 0;
  int          tests_run = 0;

  dtfm_timer dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_r), .avs_write(wr_r),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_r),
    .fosc_in(fosc_in), .flosc_in(flosc_in), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .irq_ack_a(ack_a), .irq_ack_b(ack_b), .irq_req_a(req_a), .irq_req_b(req_b)
  );

  initial forever #4 clk_sys = ~clk_sys;
  // Oscillator at clk/8, slow enough for the input synchroniser
  always @(posedge clk_sys) begin
    div_r <= div_r + 2'h1;
    if (div_r == 2'h3) fosc_in <= ~fosc_in;
    // Low-speed oscillator at clk/32
    sdiv_r <= sdiv_r + 4'h1;
    if (sdiv_r == 4'hf) flosc_in <= ~flosc_in;
  end

  task automatic err(input string m);
    num_errors++;
    $display("ERROR at %0t: %s", $time, m);
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] b, output logic [7:0] q);
    int n;
    n = 0;
    adr <= a;
    wdat <= {24'h0, d};
    be <= b;
    wr_r <= w;
    rd_r <= !w;
    // Request and read data are judged at the rising edge itself
    do begin
      @(posedge clk_sys);
      n++;
    end while (wait_r !== 1'b0 && n < 50);
    q = rdat[7:0];
    wr_r <= 1'b0;
    rd_r <= 1'b0;
    // One idle edge keeps back-to-back calls from reassigning in one step
    @(posedge clk_sys);
    if (n >= 50) err("bus hang");
  endtask
  task automatic wr(input logic [7:0] a, d, input logic [3:0] b = 4'h1);
    logic [7:0] q;
    xfer(a, 1'b1, d, b, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    xfer(a, 1'b0, 8'h00, 4'h1, q);
  endtask
  task automatic rng(input logic [7:0] a, input int lo, hi);
    logic [7:0] q;
    rd(a, q);
    tests_run++;
    if ($isunknown(q) || q < lo || q > hi) err($sformatf("reg %h read %h", a, q));
  endtask
  task automatic rchk(input logic [7:0] a, e);
    rng(a, e, e);
  endtask
  task automatic chkirq(input bit b, input logic e);
    @(posedge clk_sys);
    @(negedge clk_sys);
    tests_run++;
    if ((b ? req_b : req_a) !== e) err("irq level wrong");
    @(posedge clk_sys);
  endtask
  task automatic waitf(input logic [7:0] m);
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'h00;
    while ((d & m) !== m && n < 300) begin rd(`DTFM_IDX_CTRL, d); n++; end
    tests_run++;
    if ((d & m) !== m) err("flag never set");
  endtask

  task automatic t_reset;
    logic [7:0] al[9] = '{8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d, 8'ha8, 8'he7, 8'h00};
    foreach (al[i]) rchk(al[i], 8'h00);
    chkirq(0, 1'b0);
  endtask
  task automatic t_regs;
    wr(`DTFM_IDX_CTRL, 8'hff);
    rchk(`DTFM_IDX_CTRL, 8'h50);
    wr(`DTFM_IDX_CTRL, 8'h00);
    wr(`DTFM_IDX_A_LOW, 8'h5a);
    rchk(`DTFM_IDX_A_LOW, 8'h5a);
    wr(`DTFM_IDX_B_HIGH, 8'ha5, 4'h0);
    rchk(`DTFM_IDX_B_HIGH, 8'h00);
    wr(`DTFM_IDX_PSC, 8'hff);
    rchk(`DTFM_IDX_PSC, 8'hf7);
    wr(`DTFM_IDX_IEN, 8'hff);
    rchk(`DTFM_IDX_IEN, 8'h8a);
    wr(`DTFM_IDX_IEN, 8'h00);
  endtask
  task automatic t_mode1;
    wr(`DTFM_IDX_MODE, 8'h01);
    wr(`DTFM_IDX_A_HIGH, 8'hff);
    wr(`DTFM_IDX_A_LOW, 8'hfd);
    wr(`DTFM_IDX_IEN, 8'h82);
    wr(`DTFM_IDX_CTRL_SET, 8'h10);
    waitf(8'h20);
    wr(`DTFM_IDX_CTRL_CLR, 8'h10);
    rchk(`DTFM_IDX_A_HIGH, 8'h00);
    rng(`DTFM_IDX_A_LOW, 0, 1);
    chkirq(0, 1'b1);
    wr(`DTFM_IDX_IEN, 8'h02);
    chkirq(0, 1'b0);
    wr(`DTFM_IDX_IEN, 8'h82);
    chkirq(0, 1'b1);
    ack_a <= 1'b1;
    @(posedge clk_sys);
    ack_a <= 1'b0;
    chkirq(0, 1'b0);
    rchk(`DTFM_IDX_CTRL, 8'h00);
  endtask
  task automatic t_mode0;
    wr(`DTFM_IDX_MODE, 8'h00);
    wr(`DTFM_IDX_B_HIGH, 8'hff);
    wr(`DTFM_IDX_B_LOW, 8'hfe);
    wr(`DTFM_IDX_IEN, 8'h88);
    wr(`DTFM_IDX_CTRL_SET, 8'h40);
    waitf(8'h80);
    wr(`DTFM_IDX_CTRL_CLR, 8'h40);
    rchk(`DTFM_IDX_B_HIGH, 8'h00);
    rng(`DTFM_IDX_B_LOW, 8'he0, 8'he1);
    chkirq(1, 1'b1);
    wr(`DTFM_IDX_CTRL, 8'h00);
    chkirq(1, 1'b0);
    wr(`DTFM_IDX_IEN, 8'h00);
  endtask
  task automatic t_mode2;
    wr(`DTFM_IDX_MODE, 8'h02);
    wr(`DTFM_IDX_A_HIGH, 8'hf0);
    wr(`DTFM_IDX_A_LOW, 8'hfe);
    wr(`DTFM_IDX_CTRL_SET, 8'h10);
    waitf(8'h20);
    wr(`DTFM_IDX_CTRL_CLR, 8'h10);
    rng(`DTFM_IDX_A_LOW, 8'hf0, 8'hf1);
    rchk(`DTFM_IDX_A_HIGH, 8'hf0);
    wr(`DTFM_IDX_CTRL, 8'h00);
  endtask
  task automatic t_mode3;
    logic [7:0] v;
    wr(`DTFM_IDX_MODE, 8'h03);
    wr(`DTFM_IDX_A_LOW, 8'h00);
    wr(`DTFM_IDX_A_HIGH, 8'h00);
    wr(`DTFM_IDX_B_HIGH, 8'hff);
    wr(`DTFM_IDX_B_LOW, 8'h1f);
    wr(`DTFM_IDX_CTRL_SET, 8'h40);
    repeat (60) @(posedge clk_sys);
    rchk(`DTFM_IDX_CTRL, 8'h40);
    rchk(`DTFM_IDX_A_LOW, 8'h00);
    rchk(`DTFM_IDX_B_HIGH, 8'h00);
    rng(`DTFM_IDX_A_HIGH, 3, 7);
    wr(`DTFM_IDX_A_HIGH, 8'hff);
    waitf(8'h80);
    ack_b <= 1'b1;
    @(posedge clk_sys);
    ack_b <= 1'b0;
    rchk(`DTFM_IDX_CTRL, 8'h40);
    // Pin goes low well before the run bit so the gate is settled
    pin_a <= 1'b0;
    wr(`DTFM_IDX_CTRL, 8'h00);
    wr(`DTFM_IDX_MODE, 8'h0b);
    wr(`DTFM_IDX_CTRL_SET, 8'h50);
    repeat (60) @(posedge clk_sys);
    rchk(`DTFM_IDX_A_LOW, 8'h00);
    rng(`DTFM_IDX_A_HIGH, 3, 8);
    pin_a <= 1'b1;
    repeat (60) @(posedge clk_sys);
    rng(`DTFM_IDX_A_LOW, 3, 7);
    wr(`DTFM_IDX_CTRL_CLR, 8'h50);
    rd(`DTFM_IDX_A_LOW, v);
    repeat (40) @(posedge clk_sys);
    rchk(`DTFM_IDX_A_LOW, v);
    wr(`DTFM_IDX_CTRL, 8'h00);
  endtask
  task automatic t_ext;
    int e;
    wr(`DTFM_IDX_MODE, 8'h50);
    for (int c = 7; c >= 0; c--) begin
      e = 40 >> (7 - c);
      wr(`DTFM_IDX_PSC, c[7:0]);
      wr(`DTFM_IDX_B_LOW, 8'h00);
      wr(`DTFM_IDX_CTRL_SET, 8'h40);
      repeat (320) @(posedge clk_sys);
      wr(`DTFM_IDX_CTRL_CLR, 8'h40);
      rng(`DTFM_IDX_B_LOW, (e > 2) ? e - 2 : 0, e + 1);
    end
  endtask
  task automatic t_asrc;
    logic [7:0] v;
    wr(`DTFM_IDX_MODE, 8'h05);
    wr(`DTFM_IDX_PSC, 8'hf0);
    wr(`DTFM_IDX_A_LOW, 8'h00);
    wr(`DTFM_IDX_A_HIGH, 8'h00);
    wr(`DTFM_IDX_CTRL_SET, 8'h10);
    repeat (320) @(posedge clk_sys);
    wr(`DTFM_IDX_CTRL_CLR, 8'h10);
    rng(`DTFM_IDX_A_LOW, 9, 11);
    wr(`DTFM_IDX_PSC, 8'h60);
    wr(`DTFM_IDX_A_LOW, 8'h00);
    wr(`DTFM_IDX_CTRL_SET, 8'h10);
    repeat (320) @(posedge clk_sys);
    wr(`DTFM_IDX_CTRL_CLR, 8'h10);
    rng(`DTFM_IDX_A_LOW, 18, 21);
    wr(`DTFM_IDX_MODE, 8'h90);
    pin_b <= 1'b0;
    wr(`DTFM_IDX_B_LOW, 8'h00);
    wr(`DTFM_IDX_CTRL_SET, 8'h40);
    repeat (60) @(posedge clk_sys);
    rchk(`DTFM_IDX_B_LOW, 8'h00);
    pin_b <= 1'b1;
    repeat (60) @(posedge clk_sys);
    rng(`DTFM_IDX_B_LOW, 3, 7);
    wr(`DTFM_IDX_CTRL_CLR, 8'h40);
    rd(`DTFM_IDX_B_LOW, v);
    wr(`DTFM_IDX_MODE, 8'h30);
    wr(`DTFM_IDX_CTRL_SET, 8'h40);
    repeat (60) @(posedge clk_sys);
    rchk(`DTFM_IDX_B_LOW, v);
    rchk(`DTFM_IDX_CTRL, 8'h40);
    wr(`DTFM_IDX_CTRL, 8'h00);
  endtask

  task automatic results;
    $display("Comparisons %0d, errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Tests need roughly 4100 cycles; allow generous margin
  initial begin
    repeat (30000) @(posedge clk_sys);
    num_errors++;
    results;
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_reset;
    t_regs;
    t_mode1;
    t_mode0;
    t_mode2;
    t_mode3;
    t_ext;
    t_asrc;
    results;
  end
endmodule // dtfm_timer_tb_top
`default_nettype wire
